// ### core/sfsl_defines.vh
// Register offsets, bit positions and reset values of the status latch bank
// Notes on behaviour
// [RL1] The ground-good flag, live register 01h bit 3, is low whenever the ground pin is open.
// [RL2] The supply-good flag, 01h bit 4, is low under lockout or any reference, ground or supply overvoltage fault.
// [RL3] The reverse-good flag, 01h bit 5, is low whenever excessive reverse voltage is seen across the OR-ing transistor.
// [RL4] The OR-ing-ready flag, 01h bit 6, is the AND of pulse presence, power-enable good, load voltage good and reverse good.
// [RL5] The share-good flag, 01h bit 7, is low whenever share accuracy is out of limits.
// [RL6] The fault-latch flag, 02h bit 0, sets once an overvoltage, undervoltage or overcurrent shutdown occurs.
// [RL7] The pulse-present flag, 02h bit 1, is high while pulses are seen on the first AC sense input.
// [RL8] The overcurrent-pending flag, 02h bit 2, is high once overcurrent is sensed and its timer runs.
// [RL9] Register 02h bits 3 to 7 mirror the DC-good, power-on link, power-enable, power-on request and AC sense pins.
// [RL10] Register 2Ah holds sticky copies of monitors five down to one, overcurrent timeout, undervoltage and overvoltage.
// [RL11] Register 2Bh holds sticky supply overvoltage, reference, ground, supply, reverse, OR-ing and share faults.
// [RL12] Register 2Ch holds sticky fault latch, missing pulses, overcurrent pending and the four pin and AC sense faults.
// [RL13] A sticky flag clears when read unless its fault is still present at the read.
// [RL14] The host should keep re-reading sticky flags until they read clear.
// [RL15] Register 01h bits 0 to 2 report supply overvoltage and both reference-good flags, feeding 2Bh bits 0 to 2.
// [RL16] Register 00h bits 0 to 7 report live monitors, overcurrent timeout, undervoltage and overvoltage, feeding 2Ah.
// [RL17] Host writes are ignored and only reads of sticky registers clear anything.
`ifndef SFSL_DEFINES_VH
`define SFSL_DEFINES_VH
`define SFSL_ADDR_W 8
`define SFSL_OFS_MON_LIVE 8'h00
`define SFSL_OFS_HEALTH_LIVE 8'h01
`define SFSL_OFS_PIN_LIVE 8'h02
`define SFSL_OFS_MON_STICKY 8'h2A
`define SFSL_OFS_HEALTH_STICKY 8'h2B
`define SFSL_OFS_PIN_STICKY 8'h2C
`define SFSL_STICKY_RESET 8'h00
`define SFSL_LIVE_FAULT_LATCH_RESET 1'b0
`define SFSL_UNMAPPED_READ 8'h00
`endif

// ### core/sfsl_status_bank.v
// Live and sticky supply fault status registers with read-to-clear
`timescale 1ns/1ps
`default_nettype none
`include "sfsl_defines.vh"
module sfsl_status_bank (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Register read and write port from the serial management slave
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Raw detector conditions, asynchronous to ref_clk
  input wire [4:0] monitor_in,
  input wire ocp_timeout_in,
  input wire uv_fault_in,
  input wire ov_fault_in,
  input wire supply_ov_in,
  input wire ext_ref_good_in,
  input wire int_ref_good_in,
  input wire ground_open_in,
  input wire supply_uvlo_in,
  input wire reverse_excess_in,
  input wire power_enable_good_in,
  input wire load_voltage_good_in,
  input wire share_out_of_limit_in,
  input wire ocp_sensed_in,
  input wire first_ac_sense_pulses_in,
  // Pin levels to mirror
  input wire dc_output_good_pin,
  input wire power_on_link_pin,
  input wire power_enable_pin,
  input wire power_on_request_pin,
  input wire first_ac_sense_input,
  // Live status for other device logic
  output wire supply_good,
  output reg fault_latch
);
  // Raw inputs that cross into the clock domain, and the sticky registers
  localparam NSYNC = 24;
  localparam NSTICKY = 3;

  // Register address match, shared by the clear strobes and the read mux;
  // it keeps the compare width fixed at eight bits
  function addr_is;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  // Every raw input in one bus; the order fixes the slices taken below
  wire [NSYNC-1:0] raw_in;
  wire [NSYNC-1:0] sync_out;
  assign raw_in = {monitor_in, ocp_timeout_in, uv_fault_in, ov_fault_in,
    supply_ov_in, ext_ref_good_in, int_ref_good_in, ground_open_in,
    supply_uvlo_in, reverse_excess_in, power_enable_good_in,
    load_voltage_good_in, share_out_of_limit_in, ocp_sensed_in,
    first_ac_sense_pulses_in, dc_output_good_pin, power_on_link_pin,
    power_enable_pin, power_on_request_pin, first_ac_sense_input};

  // Detectors and pins are asynchronous; two flops per bit before any use.
  // Only the second stage is read, so a metastable first stage never leaks.
  // Write strobe and data are same-clock and take no part here
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      reg stage_a;
      reg stage_b;
      always @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          stage_a <= 1'h0;
          stage_b <= 1'h0;
        end
        else
        begin
          stage_a <= raw_in[gi];
          stage_b <= stage_a;
        end
      end
      assign sync_out[gi] = stage_b;
    end
  endgenerate

  // Synchronised conditions
  wire [4:0] mon_s = sync_out[23:19];
  wire ocpto_s = sync_out[18];
  wire uv_s = sync_out[17];
  wire ov_s = sync_out[16];
  wire vddov_s = sync_out[15];
  wire extref_s = sync_out[14];
  wire intref_s = sync_out[13];
  wire gndopen_s = sync_out[12];
  wire uvlo_s = sync_out[11];
  wire revx_s = sync_out[10];
  wire penok_s = sync_out[9];
  wire loadok_s = sync_out[8];
  wire shbad_s = sync_out[7];
  wire ocps_s = sync_out[6];
  wire pulse_s = sync_out[5];
  wire [4:0] pins_s = sync_out[4:0];

  // The synchroniser shows zeros for two edges after reset, which reads as
  // lost references and low pins; stickies collect only once it is full.
  // Two stages of fill match the two synchroniser stages
  reg [1:0] fill;
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      fill <= 2'h0;
    else
      fill <= {fill[0], 1'h1};
  end
  wire settled = fill[1];

  // Live health flags
  wire gnd_good = ~gndopen_s; // [RL1]
  // Ground open also counts as a power management fault
  assign supply_good = ~(uvlo_s | vddov_s | ~extref_s | ~intref_s
    | gndopen_s); // [RL2]
  wire reverse_good = ~revx_s; // [RL3]
  wire orfet_ready = pulse_s & penok_s & loadok_s & reverse_good; // [RL4]
  wire share_good = ~shbad_s; // [RL5]

  // Fault latch holds until reset; the power stage restarts the device.
  // A user must reset the block to clear it; a read does not
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      fault_latch <= `SFSL_LIVE_FAULT_LATCH_RESET;
    else if (ov_s | uv_s | ocpto_s)
      fault_latch <= 1'h1; // [RL6]
  end

  // Live registers; pins in bits 3 to 7 follow their levels
  wire [7:0] mon_live = {ov_s, uv_s, ocpto_s, mon_s[0], mon_s[1],
    mon_s[2], mon_s[3], mon_s[4]}; // [RL16]
  wire [7:0] health_live = {share_good, orfet_ready, reverse_good,
    supply_good, gnd_good, intref_s, extref_s, vddov_s}; // [RL15]
  wire [7:0] pin_live = {pins_s[0], pins_s[1], pins_s[2], pins_s[3],
    pins_s[4], ocps_s, pulse_s, fault_latch}; // [RL7] [RL8] [RL9]

  // Sticky sources, high while bad; monitors five down to one land in
  // bits 0 to 4, the same places as in the live register
  wire [7:0] mon_fault = mon_live; // [RL10]
  wire [7:0] health_fault = {~health_live[7:4], ~gnd_good,
    ~intref_s, ~extref_s, vddov_s}; // [RL11]
  wire [7:0] pin_fault = {~pin_live[7:3], ocps_s, ~pulse_s,
    fault_latch}; // [RL12]

  // Sticky registers, packed three bytes wide
  wire [8*NSTICKY-1:0] sticky_src;
  wire [NSTICKY-1:0] sticky_rd;
  wire [8*NSTICKY-1:0] sticky_val;
  assign sticky_src = settled ? {pin_fault, health_fault, mon_fault}
    : {8*NSTICKY{1'h0}};
  // Writes never reach any register; only sticky reads clear anything.
  // The write strobe and data are left unused inside on purpose
  assign sticky_rd[0] = reg_rd
    && addr_is(reg_addr, `SFSL_OFS_MON_STICKY); // [RL17]
  assign sticky_rd[1] = reg_rd
    && addr_is(reg_addr, `SFSL_OFS_HEALTH_STICKY); // [RL17]
  assign sticky_rd[2] = reg_rd
    && addr_is(reg_addr, `SFSL_OFS_PIN_STICKY); // [RL17]

  // One clear-on-read register per sticky byte
  genvar si;
  generate
    for (si = 0; si < NSTICKY; si = si + 1)
    begin : g_sticky
      sfsl_sticky_reg #(
        .WIDTH(8)
      ) u_sticky (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .fault_now(sticky_src[8*si+7:8*si]),
        .read_hit(sticky_rd[si]),
        .sticky(sticky_val[8*si+7:8*si])
      );
    end
  endgenerate

  // Byte views of the packed sticky buses
  wire [7:0] mon_src = sticky_src[7:0];
  wire [7:0] health_src = sticky_src[15:8];
  wire [7:0] pin_src = sticky_src[23:16];
  wire [7:0] mon_sticky = sticky_val[7:0];
  wire [7:0] health_sticky = sticky_val[15:8];
  wire [7:0] pin_sticky = sticky_val[23:16];

  // Read mux; a sticky byte is shown together with the fault seen in the
  // read cycle, since the register itself only takes that fault a cycle on
  reg [7:0] next_rdata;
  always @*
  begin
    next_rdata = `SFSL_UNMAPPED_READ;
    if (addr_is(reg_addr, `SFSL_OFS_MON_LIVE))
      next_rdata = mon_live;
    else if (addr_is(reg_addr, `SFSL_OFS_HEALTH_LIVE))
      next_rdata = health_live;
    else if (addr_is(reg_addr, `SFSL_OFS_PIN_LIVE))
      next_rdata = pin_live;
    else if (addr_is(reg_addr, `SFSL_OFS_MON_STICKY))
      next_rdata = mon_sticky | mon_src; // [RL13]
    else if (addr_is(reg_addr, `SFSL_OFS_HEALTH_STICKY))
      next_rdata = health_sticky | health_src; // [RL13]
    else if (addr_is(reg_addr, `SFSL_OFS_PIN_STICKY))
      next_rdata = pin_sticky | pin_src; // [RL13]
  end

  // Read data is registered on the strobe and holds until the next read
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= `SFSL_UNMAPPED_READ;
    else if (reg_rd)
      reg_rdata <= next_rdata; // [RL17]
  end
endmodule
`default_nettype wire

// ### core/sfsl_sticky_reg.v
// One eight-bit sticky register that clears on read unless the fault persists
`timescale 1ns/1ps
`default_nettype none
`include "sfsl_defines.vh"
module sfsl_sticky_reg #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Fault conditions, high while bad
  input wire [WIDTH-1:0] fault_now,
  // Read strobe for this register
  input wire read_hit,
  // Sticky value
  output reg [WIDTH-1:0] sticky
);
  // Set wins over the read clear, so an event in the read cycle is kept
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      sticky <= `SFSL_STICKY_RESET;
    else if (read_hit)
      sticky <= fault_now; // [RL13]
    else
      sticky <= sticky | fault_now;
  end
endmodule
`default_nettype wire

// ### verif/sfsl_bank_monitor.sv
// Port assertions for the supply fault status bank
`timescale 1ns/1ps
`default_nettype none
module sfsl_bank_monitor (
  // Clock, reset and register port
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Watched condition and status
  input wire ground_open_in,
  input wire supply_good,
  input wire fault_latch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Open ground only counts once it has passed both synchroniser stages
  logic [2:0] gh;
  always @(posedge ref_clk) gh <= reset_n ? {gh[1:0], ground_open_in} : 3'h0;
  wire g = &{gh, ground_open_in};
  wire [7:0] ra = reg_rd ? reg_addr : 8'hFF;
  chk_ground_flag: assert property (ra == 8'h01 && g |=> !reg_rdata[3])
    else $error("ground flag high while open");
  chk_supply_low: assert property (g |-> !supply_good)
    else $error("supply good high while ground open");
  chk_latch_keep: assert property (fault_latch |=> fault_latch)
    else $error("fault latch dropped without reset");
  chk_latch_read: assert property (ra == 8'h02 && fault_latch |=> reg_rdata[0])
    else $error("fault latch not reported");
  chk_pin_sticky: assert property (ra == 8'h2C && fault_latch |=> reg_rdata[0])
    else $error("sticky fault latch lost");
  chk_sticky_keep: assert property (ra == 8'h2B && g |=> reg_rdata[4:3] == 2'b11)
    else $error("persisting fault cleared by read");
  chk_unmapped_zero: assert property (ra == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  cover property (ra == 8'h2A);
  cover property (ra == 8'h2B && g);
  cover property (ra == 8'h2C && fault_latch);
endmodule
bind sfsl_status_bank sfsl_bank_monitor mon_u (.ref_clk(ref_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ground_open_in(ground_open_in),
  .supply_good(supply_good), .fault_latch(fault_latch));
`default_nettype wire

// ### verif/sfsl_host_model.sv
// Management host model that reads and writes the status bank
`timescale 1ns/1ps
`default_nettype none
module sfsl_host_model (
  // Clock and read data
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  // Request lines
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  initial {reg_addr, reg_rd, reg_wr, reg_wdata} = 18'h0;
  // Idle address shows the inverse and idle data shows the address, so stale values never match
  task automatic xfer(input logic w, input logic [7:0] ad,
    output logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_rd, reg_wr, reg_wdata} = {ad, !w, w, ~ad};
    @(negedge ref_clk);
    {reg_addr, reg_rd, reg_wr, reg_wdata} = {~ad, 2'b00, ad};
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic drain(input logic [7:0] ad);
    logic [7:0] d;
    xfer(1'b0, ad, d);
    for (int i = 0; i < 4 && d !== 8'h00; i++)
      xfer(1'b0, ad, d);
  endtask
endmodule
`default_nettype wire

// ### verif/supply_fault_status_latch_bank_tb_top.sv
// Self-checking bench for the supply fault status bank
`timescale 1ns/1ps
`default_nettype none
`define SFSL_CHK(n, e, g) begin check_count++; if ((g) !== (e)) \
  begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module supply_fault_status_latch_bank_tb_top;
  localparam logic [23:0] OK = 24'hFCC600;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] c = OK;
  logic [7:0] q;
  wire [7:0] a, d, rdata;
  wire rd, wr, sg, fl;
  int failures = 0;
  int check_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  sfsl_host_model host_u (.ref_clk(ref_clk), .reg_rdata(rdata),
    .reg_addr(a), .reg_rd(rd), .reg_wr(wr), .reg_wdata(d));
  sfsl_status_bank dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(a), .reg_rd(rd), .reg_wr(wr), .reg_wdata(d), .reg_rdata(rdata),
    .monitor_in(c[4:0]), .ocp_timeout_in(c[5]), .uv_fault_in(c[6]),
    .ov_fault_in(c[7]), .supply_ov_in(c[8]), .ext_ref_good_in(c[9]),
    .int_ref_good_in(c[10]), .ground_open_in(c[11]), .supply_uvlo_in(c[12]),
    .reverse_excess_in(c[13]), .power_enable_good_in(c[14]),
    .load_voltage_good_in(c[15]), .share_out_of_limit_in(c[16]),
    .ocp_sensed_in(c[17]), .first_ac_sense_pulses_in(c[18]),
    .dc_output_good_pin(c[19]), .power_on_link_pin(c[20]),
    .power_enable_pin(c[21]), .power_on_request_pin(c[22]),
    .first_ac_sense_input(c[23]), .supply_good(sg), .fault_latch(fl));
  task set(input logic [23:0] v);
    @(negedge ref_clk) c = v;
    repeat (4) @(negedge ref_clk);
  endtask
  task rchk(input string n, input logic [7:0] ad, e);
    host_u.xfer(1'b0, ad, q);
    `SFSL_CHK(n, e, q)
  endtask
  task automatic t_live();
    int b [8] = '{11, 12, 13, 14, 16, 8, 9, 18};
    logic [7:0] e [8] = '{8'hE6, 8'hEE, 8'h9E, 8'hBE,
      8'h7E, 8'hEF, 8'hEC, 8'hBE};
    rchk("01h", 8'h01, 8'hFE);
    `SFSL_CHK("supply_good", 1'b1, sg)
    for (int i = 0; i < 8; i++)
    begin
      set(OK ^ (24'h000001 << b[i]));
      rchk("01h", 8'h01, e[i]);
      `SFSL_CHK("supply_good", e[i][4], sg)
    end
    for (int i = 0; i < 5; i++)
    begin
      set(OK ^ (24'h080000 << i) ^ 24'h020000);
      rchk("02h", 8'h02, 8'hFE ^ (8'h08 << i));
    end
    set(OK);
    $display("live flags done");
  endtask
  task t_sticky();
    rchk("2Bh", 8'h2B, 8'hFB);
    rchk("2Bh", 8'h2B, 8'h00);
    rchk("2Ch", 8'h2C, 8'hFE);
    set(OK ^ 24'h000800);
    rchk("2Bh", 8'h2B, 8'h18);
    rchk("2Bh", 8'h2B, 8'h18);
    set(OK);
    host_u.drain(8'h2B);
    rchk("2Bh", 8'h2B, 8'h00);
    $display("sticky clear done");
  endtask
  task t_mon();
    set(OK | 24'h0000A2);
    rchk("00h", 8'h00, 8'hA8);
    set(OK);
    `SFSL_CHK("latch", 1'b1, fl)
    rchk("02h", 8'h02, 8'hFB);
    rchk("2Ah", 8'h2A, 8'hA8);
    rchk("2Ch", 8'h2C, 8'h01);
    host_u.xfer(1'b1, 8'h2A, q);
    rchk("2Ah", 8'h2A, 8'h00);
    rchk("10h", 8'h10, 8'h00);
    $display("monitor done");
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    // Inputs need two edges through the synchroniser before a read
    repeat (4) @(negedge ref_clk);
    t_live();
    t_sticky();
    t_mon();
    close_out();
  end
  initial
  begin
    #50us;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
